//--- esr_pkg.sv
// shared constants and types of the serial eeprom target
package esr_pkg;
    // clock and timing
    localparam int CLK_NS = 50;
    localparam int SPIKE_NS = 50;
    // a level must outlast the longest spike before the filter accepts it
    localparam int FILT_CYCLES = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_NS = 2000000;
    localparam int PROG_CYCLES = PROG_NS / CLK_NS;
    localparam int TIMEOUT_NS = 1000000;
    localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_NS;

    // array geometry and control byte layout
    localparam int MEM_AW = 12;
    localparam logic [3:0] CTRL_CODE = 4'hA;
    localparam logic DIR_READ = 1'h1;

    // position of each byte inside a transfer
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_AHI = 2'h1;
    localparam logic [1:0] IDX_ALO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;

    // register map, byte addresses
    localparam int REG_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic CTRL_INHIBIT_RST = 1'h0;
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_STANDBY_BIT = 1;
    localparam int ST_LOWV_BIT = 2;
    localparam int ST_PROTECT_BIT = 3;
    localparam int ST_STATE_LSB = 4;
    localparam int ST_PTR_LSB = 16;

    // bus protocol values
    localparam logic HRESP_OKAY = 1'h0;

    // protocol engine states, gray along idle-rx-ack-tx-mack
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h3,
        ST_TX = 3'h2,
        ST_MACK = 3'h6,
        ST_IGNORE = 3'h7
    } esr_state_t;
endpackage

//--- esr_line_if.sv
// filtered two-wire line levels and events between filter and core
`timescale 1ns/10ps
interface esr_line_if;
    logic sclLevel;   // filtered clock level
    logic sdaLevel;   // filtered data level
    logic sclRise;    // one-cycle pulse, clock went high
    logic sclFall;    // one-cycle pulse, clock went low
    logic startSeen;  // one-cycle pulse, data fell while clock high
    logic stopSeen;   // one-cycle pulse, data rose while clock high

    modport filt (output sclLevel, sdaLevel, sclRise, sclFall, startSeen,
        stopSeen);
    modport core (input sclLevel, sdaLevel, sclRise, sclFall, startSeen,
        stopSeen);
endinterface

//--- esr_pin_filter.sv
// synchroniser, spike filter and condition detector for the bus pins
`timescale 1ns/10ps
module esr_pin_filter
    import esr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw pins
    input wire logic sclPin,
    input wire logic sdaPin,
    // filtered view
    esr_line_if.filt line
);
    localparam int CW = $clog2(FILT_CYCLES + 1);

    typedef struct packed {
        logic [1:0] sclSync;   // two-stage synchroniser
        logic [1:0] sdaSync;
        logic [CW-1:0] sclCnt; // cycles the new level has held
        logic [CW-1:0] sdaCnt;
        logic sclF;            // accepted levels
        logic sdaF;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } esr_filt_t;

    esr_filt_t r, n;

    // accept a level only after it held FILT_CYCLES+1 samples
    always_comb begin
        n = r;
        n.sclSync = {r.sclSync[0], sclPin};
        n.sdaSync = {r.sdaSync[0], sdaPin};
        n.rise = 1'b0;
        n.fall = 1'b0;
        n.start = 1'b0;
        n.stop = 1'b0;
        if (r.sclSync[1] == r.sclF) begin
            n.sclCnt = '0;
        end else if (r.sclCnt == CW'(FILT_CYCLES)) begin
            n.sclF = r.sclSync[1];
            n.sclCnt = '0;
            n.rise = r.sclSync[1];
            n.fall = !r.sclSync[1];
        end else begin
            n.sclCnt = r.sclCnt + 1'b1;
        end
        if (r.sdaSync[1] == r.sdaF) begin
            n.sdaCnt = '0;
        end else if (r.sdaCnt == CW'(FILT_CYCLES)) begin
            n.sdaF = r.sdaSync[1];
            n.sdaCnt = '0;
            // data moving under a high clock is a condition, not a bit
            n.start = r.sclF && n.sclF && !r.sdaSync[1];
            n.stop = r.sclF && n.sclF && r.sdaSync[1];
        end else begin
            n.sdaCnt = r.sdaCnt + 1'b1;
        end
    end

    // idle bus reads high after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.sclSync <= 2'h3;
            r.sdaSync <= 2'h3;
            r.sclF <= 1'b1;
            r.sdaF <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign line.sclLevel = r.sclF;
    assign line.sdaLevel = r.sdaF;
    assign line.sclRise = r.rise;
    assign line.sclFall = r.fall;
    assign line.startSeen = r.start;
    assign line.stopSeen = r.stop;
endmodule

//--- esr_target.sv
// two-wire serial eeprom target with sequential read and write guards
`timescale 1ns/10ps

// Functional notes
// - acked read byte is followed by next byte
// - one pointer, plus one per byte
// - pointer wraps from top to zero
// - answer only when select bits match straps
// - data line only pulled low or released
// - transmitter changes data only while clock low
// - data change under high clock is condition
// - protect low allows full read and write
// - protect high blocks writes, reads unchanged
// - filter spikes on clock and data inputs
// - standby after stop and finished activity
// - standby after missing ack or stop
// - low supply blocks writes; monitor off standby
// - control byte: code, select, direction bit
// - two address bytes, msb first, twelve used
// - no acknowledge while programming runs
// - on nack release data line high
module esr_target
    import esr_pkg::*;
#(
    parameter int ADDR_W = MEM_AW,
    parameter int PROG_CYC = PROG_CYCLES,
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
)(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus, ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // two-wire bus, data line as open drain
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOeN,
    // straps and supply monitor
    input wire logic selectStrapLow,
    input wire logic selectStrapMid,
    input wire logic selectStrapHigh,
    input wire logic writeProtect,
    input wire logic supplyLow
);
    localparam int PCW = $clog2(PROG_CYC + 1);
    localparam int TCW = $clog2(TIMEOUT_CYC + 1);
    localparam int DEPTH = 1 << ADDR_W;

    typedef struct packed {
        esr_state_t state;          // protocol engine state
        logic [1:0] byteIdx;        // which byte of the transfer
        logic [2:0] bitCnt;         // bit within the byte
        logic full;                 // eight bits received
        logic [7:0] shift;          // receive and transmit shifter
        logic readMode;             // direction of this transfer
        logic mAck;                 // controller acked last byte
        logic [ADDR_W-1:0] ptr;     // internal address pointer
        logic [DEPTH-1:0][7:0] mem; // the array
        logic pendingProg;          // a data byte was stored
        logic busy;                 // programming cycle running
        logic [PCW-1:0] progCnt;    // programming timer
        logic [TCW-1:0] idleCnt;    // clock inactivity timer
        logic [4:0] strap0;         // strap synchroniser, stage one
        logic [4:0] strap1;         // strap synchroniser, stage two
        logic lowVolt;              // held monitor reading
        logic wrInhibit;            // software write lock
        logic ahbWr;                // write data phase pending
        logic [REG_AW-1:0] ahbAddr; // address of that write
        logic [31:0] rdata;         // read data for the data phase
        logic readyOut;             // bus ready, zero wait states
        logic respOut;              // bus response
        logic sdaOut;               // low level driven when enabled
        logic sdaOeN;               // low while pulling the line low
    } esr_core_t;

    esr_core_t r, n;
    esr_line_if line ();

    logic standby;     // nothing in flight, monitor may sleep
    logic writeOk;     // an array write is allowed now
    logic addrMatch;   // control byte addresses this device
    logic [31:0] statusWord;

    // spike filter and condition detection on the raw pins
    esr_pin_filter u_filter (
        .clk(clk),
        .reset(reset),
        .sclPin(sclPin),
        .sdaPin(sdaPin),
        .line(line)
    );

    // standby once no transfer and no programming remain
    assign standby = (r.state == ST_IDLE) && !r.busy;

    // straps order: supply, protect, high, mid, low select
    assign writeOk = !r.strap1[3] && !r.lowVolt && !r.wrInhibit;

    // control byte check against code and straps, refused while busy
    assign addrMatch = (r.shift[7:4] == CTRL_CODE) &&
        (r.shift[3:1] == r.strap1[2:0]) &&
        !r.busy;

    // status view for the register bus
    always_comb begin
        statusWord = '0;
        statusWord[ST_BUSY_BIT] = r.busy;
        statusWord[ST_STANDBY_BIT] = standby;
        statusWord[ST_LOWV_BIT] = r.lowVolt;
        statusWord[ST_PROTECT_BIT] = r.strap1[3];
        statusWord[ST_STATE_LSB +: 3] = r.state;
        statusWord[ST_PTR_LSB +: ADDR_W] = r.ptr;
    end

    // next state of the whole block
    always_comb begin
        logic loadNext;
        loadNext = 1'b0;
        n = r;

        // straps and monitor are pins: two flip-flops before use
        n.strap0 = {supplyLow, writeProtect, selectStrapHigh,
            selectStrapMid, selectStrapLow};
        n.strap1 = r.strap0;
        // monitor is powered down in standby, so its reading is frozen
        if (!standby) begin
            n.lowVolt = r.strap1[4];
        end

        // self-timed programming cycle
        if (r.busy) begin
            if (r.progCnt == PCW'(PROG_CYC - 1)) begin
                n.busy = 1'b0;
                n.progCnt = '0;
            end else begin
                n.progCnt = r.progCnt + 1'b1;
            end
        end

        // a controller that vanishes mid-transfer must not hang us
        if (r.state == ST_IDLE || line.sclRise || line.sclFall) begin
            n.idleCnt = '0;
        end else if (r.idleCnt == TCW'(TIMEOUT_CYC - 1)) begin
            n.idleCnt = '0;
            n.state = ST_IDLE;
            n.sdaOeN = 1'b1;
        end else begin
            n.idleCnt = r.idleCnt + 1'b1;
        end

        // bit engine; the line is only released or pulled low
        case (r.state)
            ST_RX: begin
                // sample while the clock is high
                if (line.sclRise) begin
                    n.shift = {r.shift[6:0], line.sdaLevel};
                    n.bitCnt = r.bitCnt + 1'b1;
                    n.full = (r.bitCnt == 3'h7);
                end
                // decide the acknowledge only after the clock is low
                if (line.sclFall && r.full) begin
                    n.full = 1'b0;
                    n.sdaOeN = 1'b0;
                    n.state = ST_ACK;
                    case (r.byteIdx)
                        IDX_CTRL: begin
                            if (addrMatch) begin
                                n.readMode = (r.shift[0] == DIR_READ);
                                n.byteIdx = IDX_AHI;
                            end else begin
                                n.sdaOeN = 1'b1;
                                n.state = ST_IGNORE;
                            end
                        end
                        IDX_AHI: begin
                            // upper four bits are expected zero, unused
                            n.ptr[ADDR_W-1:8] = r.shift[ADDR_W-9:0];
                            n.byteIdx = IDX_ALO;
                        end
                        IDX_ALO: begin
                            n.ptr[7:0] = r.shift;
                            n.byteIdx = IDX_DATA;
                        end
                        default: begin
                            // protected bytes are acked but not stored
                            if (writeOk) begin
                                n.mem[r.ptr] = r.shift;
                                n.pendingProg = 1'b1;
                            end
                            n.ptr = r.ptr + 1'b1;
                        end
                    endcase
                end
            end
            ST_ACK: begin
                // end of our acknowledge pulse
                if (line.sclFall) begin
                    n.sdaOeN = 1'b1;
                    n.bitCnt = '0;
                    if (r.readMode) begin
                        loadNext = 1'b1;
                    end else begin
                        n.state = ST_RX;
                    end
                end
            end
            ST_TX: begin
                // next bit goes out just after the falling edge
                if (line.sclFall) begin
                    if (r.bitCnt == 3'h7) begin
                        n.sdaOeN = 1'b1;
                        n.bitCnt = '0;
                        n.state = ST_MACK;
                    end else begin
                        n.bitCnt = r.bitCnt + 1'b1;
                        n.shift = {r.shift[6:0], 1'b0};
                        n.sdaOeN = r.shift[6];
                    end
                end
            end
            ST_MACK: begin
                // controller answers in the ninth slot
                if (line.sclRise) begin
                    n.mAck = !line.sdaLevel;
                end
                if (line.sclFall) begin
                    if (r.mAck) begin
                        loadNext = 1'b1;
                    end else begin
                        // leave the line high so a stop can follow
                        n.sdaOeN = 1'b1;
                        n.state = ST_IDLE;
                    end
                end
            end
            default: begin
                // idle or not addressed: wait for a condition
                n.sdaOeN = 1'b1;
            end
        endcase

        // fetch a byte; the pointer wraps naturally at its width
        if (loadNext) begin
            n.shift = r.mem[r.ptr];
            n.sdaOeN = r.mem[r.ptr][7];
            n.ptr = r.ptr + 1'b1;
            n.bitCnt = '0;
            n.state = ST_TX;
        end

        // conditions override whatever the engine was doing
        if (line.startSeen) begin
            n.state = ST_RX;
            n.byteIdx = IDX_CTRL;
            n.bitCnt = '0;
            n.full = 1'b0;
            n.readMode = 1'b0;
            n.sdaOeN = 1'b1;
        end else if (line.stopSeen) begin
            n.state = ST_IDLE;
            n.sdaOeN = 1'b1;
            // only a stop after stored data launches programming
            if (r.pendingProg) begin
                n.pendingProg = 1'b0;
                n.busy = 1'b1;
                n.progCnt = '0;
            end
        end

        // register bus: write lands in the data phase
        n.readyOut = 1'b1;
        n.respOut = HRESP_OKAY;
        n.ahbWr = 1'b0;
        if (r.ahbWr) begin
            if (r.ahbAddr == REG_CTRL) begin
                n.wrInhibit = hwdata[CTRL_INHIBIT_BIT];
            end
        end
        // address phase: capture, and prepare read data for next cycle
        if (hsel && htrans[1] && hready) begin
            n.ahbWr = hwrite;
            n.ahbAddr = haddr[REG_AW-1:0];
            n.rdata = '0;
            if (hwrite) begin
                n.rdata = '0;
            end else if (haddr[REG_AW-1:0] == REG_CTRL) begin
                n.rdata[CTRL_INHIBIT_BIT] = r.wrInhibit;
            end else if (haddr[REG_AW-1:0] == REG_STATUS) begin
                n.rdata = statusWord;
            end else begin
                // unmapped offsets read as zero
                n.rdata = '0;
            end
        end
    end

    // single register of the whole state; reset is power-up
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.wrInhibit <= CTRL_INHIBIT_RST;
            r.readyOut <= 1'b1;
            r.respOut <= HRESP_OKAY;
            r.sdaOeN <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flip-flops
    assign hreadyout = r.readyOut;
    assign hrdata = r.rdata;
    assign hresp = r.respOut;
    assign sdaOut = r.sdaOut;
    assign sdaOeN = r.sdaOeN;
endmodule

//--- esr_target_asserts.sv
// port-level checks of the serial eeprom target
`timescale 1ns/10ps
module esr_target_asserts
    import esr_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
)(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // two-wire pins
    input wire logic sclPin,
    input wire logic sdaOut,
    input wire logic sdaOeN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // cycles since the clock pin moved
    logic [31:0] sclStill_r;
    logic sclPrev_r;
    // counter restarts on every clock pin move
    always_ff @(posedge clk) begin
        sclPrev_r <= sclPin;
        if (reset || sclPin != sclPrev_r) begin
            sclStill_r <= 32'h0;
        end else if (sclStill_r != 32'hFFFFFFFF) begin
            sclStill_r <= sclStill_r + 32'h1;
        end
    end
    // accepted address phase, and an accepted read of an unmapped offset
    sequence busAcc;
        hsel && htrans[1] && hready;
    endsequence
    sequence unmappedRd;
        busAcc ##0 (!hwrite && haddr[7:0] != REG_CTRL
            && haddr[7:0] != REG_STATUS);
    endsequence
    hready_one_a: assert property (hreadyout)
        else $error("wait state inserted");
    resp_okay_a: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    unmapped_zero_a: assert property (unmappedRd |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!(hsel && htrans[1] && hready)
        |=> $stable(hrdata)) else $error("read data moved while idle");
    sda_level_a: assert property (!sdaOeN |-> sdaOut == 1'b0)
        else $error("data line driven high");
    sda_change_a: assert property ($changed(sdaOeN)
        && sclStill_r < TIMEOUT_CYC |-> !sclPin)
        else $error("data changed while clock high");
    pull_hold_a: assert property ($fell(sdaOeN) |-> !sdaOeN [*4])
        else $error("driven low bit too short");
    boot_release_a: assert property ($fell(reset) |-> sdaOeN [*4])
        else $error("data line pulled after reset");
    idle_release_a: assert property
        (sclStill_r > TIMEOUT_CYC + 16 |-> sdaOeN)
        else $error("data line held after timeout");
endmodule

bind esr_target esr_target_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sclPin(sclPin), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

//--- esr_ctl_model.sv
// behavioural two-wire bus controller that drives the serial clock
`timescale 1ns/10ps
module esr_ctl_model (
    // bus lines, data as open drain (low = pull low)
    output logic scl,
    output logic ctlSdaOeN,
    input wire logic sdaWire
);
    // both lines rest high between frames
    initial begin
        scl = 1'b1;
        ctlSdaOeN = 1'b1;
    end
    // one bit: data moves mid-low, sampled at end of high
    task automatic bitIo(input logic b, output logic r);
        scl = 1'b0;
        #150 ctlSdaOeN = b;
        #150 scl = 1'b1;
        #100 r = sdaWire;
    endtask
    // start, also usable as a repeated start
    task automatic start();
        #10 scl = 1'b0;
        #150 ctlSdaOeN = 1'b1;
        #150 scl = 1'b1;
        #200 ctlSdaOeN = 1'b0;
        #200 scl = 1'b0;
    endtask
    // stop leaves both lines high
    task automatic stop();
        scl = 1'b0;
        #150 ctlSdaOeN = 1'b0;
        #150 scl = 1'b1;
        #200 ctlSdaOeN = 1'b1;
        #190;
    endtask
    // msb first; nak is the ack slot level
    task automatic sendByte(input logic [7:0] b, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(b[i], r);
        end
        bitIo(1'b1, nak);
    endtask
    // release for eight bits, then ack or withhold it
    task automatic recvByte(input logic nak, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, b[i]);
        end
        bitIo(nak, r);
    endtask
    // 50 ns data glitch, clear of clock edges
    task automatic spike();
        #10 ctlSdaOeN = 1'b0;
        #50 ctlSdaOeN = 1'b1;
    endtask
endmodule

//--- eeprom_seq_read_protect_test.sv
// self-checking bench of the serial eeprom target
`timescale 1ns/10ps
module eeprom_seq_read_protect_test
    import esr_pkg::*;
;
    localparam int PROG = 400;
    localparam int TMO = 2000;
    localparam int LIMIT = 60000;
    // control bytes for straps 101
    localparam logic [7:0] CTL_WR = 8'hAA;
    localparam logic [7:0] CTL_RD = 8'hAB;
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin failCount++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (e)); end end
    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic scl, sdaOut, sdaOeN, ctlSdaOeN, sdaWire;
    logic writeProtect, supplyLow, sLow, sMid, sHigh;
    int failCount, nCompared, cycles;
    // pull-up wire: low if either party pulls
    assign sdaWire = (sdaOeN | sdaOut) & ctlSdaOeN;
    assign hready = hreadyout;
    esr_target #(.PROG_CYC(PROG), .TIMEOUT_CYC(TMO)) i_dut (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .sclPin(scl), .sdaPin(sdaWire), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .selectStrapLow(sLow), .selectStrapMid(sMid),
        .selectStrapHigh(sHigh), .writeProtect(writeProtect),
        .supplyLow(supplyLow));
    esr_ctl_model i_ctl (.scl(scl), .ctlSdaOeN(ctlSdaOeN),
        .sdaWire(sdaWire));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // verdict and end of run
    task automatic summarize();
        if (failCount == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failCount++;
            summarize();
        end
    end
    // one single transfer: address phase, then data phase
    task automatic busCycle(input logic [31:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask
    // status once the filter settles
    task automatic status(output logic [31:0] s);
        repeat (12) @(posedge clk);
        busCycle({24'h0, REG_STATUS}, 1'b0, 32'h0, s);
    endtask
    // start, write control byte and both address bytes
    task automatic addrSet(input logic [11:0] a);
        logic n;
        i_ctl.start();
        i_ctl.sendByte(CTL_WR, n);
        `CHK(n, 1'b0)
        i_ctl.sendByte({4'h0, a[11:8]}, n);
        `CHK(n, 1'b0)
        i_ctl.sendByte(a[7:0], n);
        `CHK(n, 1'b0)
    endtask
    // random read then cnt bytes, last one not acked
    task automatic readSeq(input logic [11:0] a, input int cnt,
        input logic [23:0] exp);
        logic n;
        logic [7:0] b;
        addrSet(a);
        i_ctl.start();
        i_ctl.sendByte(CTL_RD, n);
        `CHK(n, 1'b0)
        for (int k = 0; k < cnt; k++) begin
            i_ctl.recvByte(k == cnt - 1, b);
            `CHK(b, exp[23 - 8 * k -: 8])
        end
    endtask
    // reset values, readback, unmapped offset, idle status
    task automatic tRegs();
        logic [31:0] r;
        busCycle(32'h0, 1'b0, 32'h0, r);
        `CHK(r, 32'h0)
        busCycle(32'h10, 1'b1, 32'hFFFFFFFF, r);
        busCycle(32'h10, 1'b0, 32'h0, r);
        `CHK(r, 32'h0)
        busCycle(32'h0, 1'b1, 32'h1, r);
        busCycle(32'h0, 1'b0, 32'h0, r);
        `CHK(r, 32'h1)
        busCycle(32'h0, 1'b1, 32'h0, r);
        status(r);
        `CHK(r[ST_STANDBY_BIT], 1'b1)
    endtask
    // glitch ignored, real start and stop recognised
    task automatic tSpike();
        logic [31:0] r;
        i_ctl.spike();
        status(r);
        `CHK(r[ST_STATE_LSB +: 3], ST_IDLE)
        i_ctl.start();
        status(r);
        `CHK(r[ST_STATE_LSB +: 3], ST_RX)
        i_ctl.stop();
        status(r);
        `CHK(r[ST_STATE_LSB +: 3], ST_IDLE)
    endtask
    // three bytes across the top, then busy refuses a control byte
    task automatic tWrite();
        logic [31:0] r;
        logic n;
        addrSet(12'hFFE);
        for (int k = 1; k <= 3; k++) begin
            i_ctl.sendByte(8'h11 * k, n);
            `CHK(n, 1'b0)
        end
        i_ctl.stop();
        status(r);
        `CHK(r[ST_BUSY_BIT], 1'b1)
        i_ctl.start();
        i_ctl.sendByte(CTL_WR, n);
        `CHK(n, 1'b1)
        i_ctl.stop();
        for (int k = 0; k < 50 && r[ST_BUSY_BIT] !== 1'b0; k++) status(r);
        `CHK(r[ST_BUSY_BIT], 1'b0)
    endtask
    // stream through the wrap, nack, pointer after
    task automatic tSeq();
        logic [31:0] r;
        readSeq(12'hFFE, 3, 24'h112233);
        status(r);
        `CHK(r[ST_STATE_LSB +: 3], ST_MACK)
        i_ctl.stop();
        status(r);
        `CHK(r[ST_PTR_LSB +: 12], 12'h001)
        `CHK(r[ST_STANDBY_BIT], 1'b1)
    endtask
    // every select value and one wrong type code
    task automatic tSelect();
        logic n;
        for (int k = 0; k < 9; k++) begin
            i_ctl.start();
            i_ctl.sendByte(k < 8 ? {4'hA, k[2:0], 1'b0} : 8'hBA, n);
            i_ctl.stop();
            `CHK(n, k != 5)
        end
    endtask
    // strap, low supply, inhibit: acked but array unchanged
    task automatic tProtect();
        logic [31:0] r;
        logic n;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            writeProtect <= (k == 0);
            supplyLow <= (k == 1);
            if (k == 2) busCycle(32'h0, 1'b1, 32'h1, r);
            addrSet(12'hFFE);
            i_ctl.sendByte(8'h55, n);
            `CHK(n, 1'b0)
            i_ctl.stop();
            status(r);
            `CHK(r[ST_BUSY_BIT], 1'b0)
            `CHK(r[ST_PROTECT_BIT], k == 0)
            @(posedge clk);
            writeProtect <= 1'b0;
            supplyLow <= 1'b0;
            busCycle(32'h0, 1'b1, 32'h0, r);
            readSeq(12'hFFE, 1, 24'h110000);
            i_ctl.stop();
        end
    endtask
    // clock stalls after an acked control byte
    task automatic tTimeout();
        logic [31:0] r;
        logic n;
        i_ctl.start();
        i_ctl.sendByte(CTL_WR, n);
        `CHK(n, 1'b0)
        repeat (TMO + 100) @(posedge clk);
        `CHK(sdaOeN, 1'b1)
        status(r);
        `CHK(r[ST_STATE_LSB +: 3], ST_IDLE)
        i_ctl.stop();
    endtask
    // main sequence
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        writeProtect = 1'b0;
        supplyLow = 1'b0;
        sLow = 1'b1;
        sMid = 1'b0;
        sHigh = 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        tRegs();
        tSpike();
        tWrite();
        tSeq();
        tSelect();
        tProtect();
        tTimeout();
        summarize();
    end
endmodule
